// ==== bench/rxpk_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module rxpk_checker
    import rxpk_pkg::*;
(
    // clock, reset and inputs
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        sym_valid,
    input  wire logic [9:0]  sym,
    input  wire logic        sym_disp_err,
    input  wire logic        sym_patt,
    input  wire logic        sym_rdisp,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    // outputs watched
    input  wire logic [31:0] rx_word,
    input  wire logic        rx_word_valid,
    input  wire logic        rx_rate_div2,
    input  wire logic        tx_rate_div2,
    input  wire logic        wb_ack_o,
    input  wire logic        wb_err_o
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic take;
    logic mapped;
    // a request already answered is not a new one
    assign take = wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o && !wb_err_o;
    assign mapped = wb_adr_i inside {RXPK_CTRL_OFS, RXPK_STAT_OFS,
        RXPK_IRQ_OFS, RXPK_MASK_OFS, RXPK_WORD_OFS};
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_bus_answer: assert property (take |=> wb_ack_o ^ wb_err_o)
        else $error("bus request not answered next cycle");
    a_err_unmapped: assert property (take && !mapped |=> wb_err_o)
        else $error("unmapped address not refused");
    a_tx_rate_fixed: assert property (!tx_rate_div2)
        else $error("transmit rate moved");
    a_word_pulse: assert property (rx_word_valid |=> !rx_word_valid)
        else $error("word valid longer than one cycle");
    a_high_flags: assert property (rx_word_valid |-> $past(sym_valid)
        && rx_word[27] == $past(sym_disp_err) && rx_word[28] == $past(sym_patt)
        && rx_word[31] == $past(sym_rdisp))
        else $error("high slot flags not from last symbol");
    a_high_data: assert property (rx_word_valid
        |-> rx_word[23:16] == $past(sym[7:0]))
        else $error("high slot data not from last symbol");
    a_rate_select: assert property (take && wb_we_i && wb_sel_i[0]
        && wb_adr_i == RXPK_CTRL_OFS
        |-> ##2 rx_rate_div2 == $past(wb_dat_i[RXPK_CTRL_DIV2_BIT], 2))
        else $error("receive rate select not applied");
endmodule : rxpk_checker
bind rxpk_packer rxpk_checker i_rxpk_checker (.sys_clk(sys_clk), .rst(rst),
    .clk_en(clk_en), .sym_valid(sym_valid), .sym(sym),
    .sym_disp_err(sym_disp_err), .sym_patt(sym_patt), .sym_rdisp(sym_rdisp),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .rx_word(rx_word), .rx_word_valid(rx_word_valid),
    .rx_rate_div2(rx_rate_div2), .tx_rate_div2(tx_rate_div2),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
`default_nettype wire

// ==== bench/rxpk_fabric_sink.sv ====
`timescale 1ns/100ps
`default_nettype none
module rxpk_fabric_sink (
    // receive word from the packer
    input  wire logic        sys_clk,
    input  wire logic [31:0] rx_word,
    input  wire logic        rx_word_valid
);
    // fabric consumer never stalls; it keeps every word for the bench
    logic [31:0] got_q[$];
    always @(posedge sys_clk) begin
        if (rx_word_valid) got_q.push_back(rx_word);
    end
endmodule : rxpk_fabric_sink
`default_nettype wire

// ==== bench/rxpk_packer_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module rxpk_packer_tb;
    import rxpk_pkg::*;
    logic sys_clk = 0, rst = 1, clk_en = 1, sym_valid = 0, align_pin = 1;
    logic sym_ctrl = 0, sym_cviol = 0, sym_disp_err = 0, sym_patt = 0;
    logic sym_rm_del = 0, sym_rm_ins = 0, sym_rdisp = 0;
    logic [9:0] sym = 0;
    logic [1:0] sym_pipe_st = 0;
    logic [7:0] wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rx_word, q;
    logic [3:0] wb_sel_i = 0;
    logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o, wb_err_o, e;
    logic rx_word_valid, rx_rate_div2, tx_rate_div2, irq;
    int bad_count = 0, n_checks = 0;
    integer seed = 32'hE59055C8;
    logic [31:0] exp_q[$];
    always #20 sys_clk = ~sys_clk;
    rxpk_packer i_rxpk_packer (.*);
    rxpk_fabric_sink i_rxpk_fabric_sink (.sys_clk(sys_clk), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid));
    task automatic chk(string what, logic [31:0] ex, logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, ex, got);
        end
    endtask : chk
    task automatic wb(logic [7:0] a, logic w, logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        {wb_adr_i, wb_we_i, wb_dat_i, wb_sel_i} <= {a, w, d, 4'hF};
        {wb_cyc_i, wb_stb_i} <= 2'b11;
        do begin @(posedge sys_clk); n++; end
        while (!(wb_ack_o | wb_err_o) && n < 50);
        q = wb_dat_o;
        e = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task automatic send(int n, logic [1:0] md, bit d2, bit fd);
        logic [31:0] r;
        logic [15:0] s, lo;
        bit odd = 0, have = 0;
        repeat (n) begin
            @(posedge sys_clk);
            r = $random(seed);
            r[14] |= fd;
            sym_valid <= 1;
            sym <= r[9:0];
            {sym_ctrl, sym_cviol, sym_disp_err, sym_patt, sym_rm_del,
                sym_rm_ins, sym_rdisp} <= r[16:10];
            sym_pipe_st <= r[18:17];
            s = {r[10], (md == 2) ? r[18:17] : {r[11], r[12]}, r[13], r[14],
                1'b1, (md == 1) ? r[9:0] : {r[15], r[16], r[7:0]}};
            if (!odd) begin
                if (have) exp_q.push_back({s, lo});
                lo = s;
                have = !have;
            end
            odd = d2 && !odd;
        end
        @(posedge sys_clk);
        sym_valid <= 0;
        repeat (3) @(posedge sys_clk);
        chk("words", exp_q.size(), i_rxpk_fabric_sink.got_q.size());
        while (exp_q.size() && i_rxpk_fabric_sink.got_q.size())
            chk("rx_word", exp_q.pop_front(), i_rxpk_fabric_sink.got_q.pop_front());
        exp_q.delete();
    endtask : send
    task automatic report_and_stop;
        if (bad_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        wb(RXPK_CTRL_OFS, 0, 0);
        chk("ctrl", 32'h8, q & 32'hF);
        for (int m = 0; m < 3; m++) begin
            wb(RXPK_CTRL_OFS, 1, 32'h8 | m);
            send(6, m, 0, 0);
        end
        wb(RXPK_CTRL_OFS, 1, 32'hC);
        send(8, 0, 1, 0);
        chk("rx_rate_div2", 1, rx_rate_div2);
        chk("tx_rate_div2", 0, tx_rate_div2);
        wb(RXPK_CTRL_OFS, 1, 32'h8);
        wb(8'h20, 0, 0);
        chk("err", 1, e);
        wb(RXPK_IRQ_OFS, 1, 32'hF);
        wb(RXPK_MASK_OFS, 1, 32'h2);
        send(2, 0, 0, 1);
        chk("irq", 1, irq);
        wb(RXPK_IRQ_OFS, 0, 0);
        chk("irq_status", 2, q & 32'h2);
        wb(RXPK_IRQ_OFS, 1, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk("irq", 0, irq);
        wb(RXPK_MASK_OFS, 1, 0);
        send(2, 0, 0, 1);
        chk("irq", 0, irq);
        report_and_stop();
    end
endmodule : rxpk_packer_tb
`default_nettype wire

// ==== common/rxpk_pkg.sv ====
package rxpk_pkg;

    // ========================================================================
    // receive word layout, low slot; high slot adds the slot offset
    localparam int RXPK_SLOT_OFS     = 16;
    localparam int RXPK_DATA_LSB     = 0;
    localparam int RXPK_CTRL_BIT     = 8;
    localparam int RXPK_CVIOL_BIT    = 9;
    localparam int RXPK_ALIGN_BIT    = 10;
    localparam int RXPK_DISP_BIT     = 11;
    localparam int RXPK_PATT_BIT     = 12;
    localparam int RXPK_DEL_BIT      = 13;
    localparam int RXPK_INS_BIT      = 14;
    localparam int RXPK_RDISP_BIT    = 15;

    // ========================================================================
    // register map (byte addresses)
    localparam logic [7:0] RXPK_CTRL_OFS   = 8'h00;
    localparam logic [7:0] RXPK_STAT_OFS   = 8'h04;
    localparam logic [7:0] RXPK_IRQ_OFS    = 8'h08;
    localparam logic [7:0] RXPK_MASK_OFS   = 8'h0C;
    localparam logic [7:0] RXPK_WORD_OFS   = 8'h10;

    // ctrl fields
    localparam int RXPK_CTRL_MODE_LSB = 0;
    localparam int RXPK_CTRL_DIV2_BIT = 2;
    localparam int RXPK_CTRL_EN_BIT   = 3;
    localparam logic [3:0] RXPK_CTRL_RST = 4'h8;

    // interrupt events
    localparam int RXPK_EV_ALIGN_LOSS = 0;
    localparam int RXPK_EV_DISP       = 1;
    localparam int RXPK_EV_CVIOL      = 2;
    localparam int RXPK_EV_RM         = 3;
    localparam int RXPK_EV_N          = 4;

    localparam int RXPK_SYNC_STAGES   = 3;

    // ========================================================================
    typedef enum logic [1:0] {
        RXPK_MODE_W16 = 2'b00,
        RXPK_MODE_W20 = 2'b01,
        RXPK_MODE_PIPE = 2'b10
    } rxpk_mode_t;

endpackage : rxpk_pkg

// ==== logic/rxpk_packer.sv ====
// Notes on behaviour
// - low alignment flag on bit 10, high on bit 26.
// - disparity error on bit 11 low, bit 27 high.
// - pattern detect on bit 12 low, bit 28 high.
// - outside pipe mode, rate-match deletion on bits 13 and 29.
// - outside pipe mode, rate-match insertion on bits 14 and 30.
// - in pipe mode, bits 14:13 and 30:29 carry two-bit receive status.
// - running disparity after each symbol on bits 15 and 31.
// - in 20-bit mode raw symbols sit on bits 9:0 and 25:16.
// - a selectable divide-by-two of the receive rate is offered.
// - the divide-by-two touches only the receive path.
// - in 16-bit mode decoded bytes sit on bits 7:0 and 23:16.
// - in 16-bit mode control flag on 8/24, violation on 9/25.
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module rxpk_packer
    import rxpk_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // symbol stream from decoder, one symbol per strobe
    input  wire logic        sym_valid,
    input  wire logic [9:0]  sym,
    input  wire logic        sym_ctrl,
    input  wire logic        sym_cviol,
    input  wire logic        sym_disp_err,
    input  wire logic        sym_patt,
    input  wire logic        sym_rm_del,
    input  wire logic        sym_rm_ins,
    input  wire logic [1:0]  sym_pipe_st,
    input  wire logic        sym_rdisp,
    // alignment level from the link pin
    input  wire logic        align_pin,
    // receive word out
    output logic      [31:0] rx_word,
    output logic             rx_word_valid,
    output logic             rx_rate_div2,
    output logic             tx_rate_div2,
    // wishbone slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // interrupt
    output logic             irq
);
    // ========================================================================
    // register state
    logic [3:0]            ctrl_ff;
    logic [RXPK_EV_N-1:0]  irq_ff;
    logic [RXPK_EV_N-1:0]  mask_ff;
    logic                  ack_ff;
    logic                  err_ff;
    logic [31:0]           rdat_ff;
    logic [RXPK_SYNC_STAGES-1:0] align_sync_ff;
    logic                  align_ff;
    logic                  div_ph_ff;
    logic                  half_ff;
    logic [15:0]           low_ff;
    logic [31:0]           word_ff;
    logic                  word_vld_ff;

    logic [1:0]            mode;
    logic                  div2;
    logic                  enable;
    logic                  sym_take;
    logic [15:0]           cur_slot;
    logic                  bus_req;
    logic                  bus_wr;
    logic                  addr_ok;
    logic [RXPK_EV_N-1:0]  events;
    logic [RXPK_EV_N-1:0]  nxt_irq;

    assign mode   = ctrl_ff[RXPK_CTRL_MODE_LSB +: 2];
    assign div2   = ctrl_ff[RXPK_CTRL_DIV2_BIT];
    assign enable = ctrl_ff[RXPK_CTRL_EN_BIT];

    function automatic logic adr_valid(input logic [7:0] a);
        adr_valid = (a == RXPK_CTRL_OFS) || (a == RXPK_STAT_OFS) ||
                    (a == RXPK_IRQ_OFS)  || (a == RXPK_MASK_OFS) ||
                    (a == RXPK_WORD_OFS);
    endfunction : adr_valid

    // ========================================================================
    // alignment pin synchroniser: change counts when stages 2 and 3 agree
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            align_sync_ff <= '0;
            align_ff      <= 1'b0;
        end else if (clk_en) begin
            align_sync_ff <= {align_sync_ff[RXPK_SYNC_STAGES-2:0], align_pin};
            if (align_sync_ff[2] == align_sync_ff[1]) begin
                align_ff <= align_sync_ff[2];
            end
        end
    end

    // ========================================================================
    // rate divider: in half rate every other symbol strobe is dropped
    // receive divide by two
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_ph_ff <= 1'b0;
        end else if (clk_en) begin
            if (!div2) begin
                div_ph_ff <= 1'b0;
            end else if (sym_valid) begin
                div_ph_ff <= ~div_ph_ff;
            end
        end
    end

    assign sym_take     = enable && sym_valid && (!div2 || !div_ph_ff);
    assign rx_rate_div2 = div2;
    assign tx_rate_div2 = 1'b0;

    // ========================================================================
    // per-symbol slot formatting
    rxpk_slot u_slot (
        .sym      (sym),
        .ctrl     (sym_ctrl),
        .cviol    (sym_cviol),
        .align    (align_ff),
        .disp_err (sym_disp_err),
        .patt     (sym_patt),
        .rm_del   (sym_rm_del),
        .rm_ins   (sym_rm_ins),
        .pipe_st  (sym_pipe_st),
        .rdisp    (sym_rdisp),
        .mode     (mode),
        .slot     (cur_slot)
    );

    // ========================================================================
    // word assembly
    // earlier symbol low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            half_ff     <= 1'b0;
            low_ff      <= '0;
            word_ff     <= '0;
            word_vld_ff <= 1'b0;
        end else if (clk_en) begin
            word_vld_ff <= 1'b0;
            if (!enable) begin
                half_ff <= 1'b0;
            end else if (sym_take) begin
                if (!half_ff) begin
                    low_ff  <= cur_slot;
                    half_ff <= 1'b1;
                end else begin
                    word_ff     <= {cur_slot, low_ff};
                    word_vld_ff <= 1'b1;
                    half_ff     <= 1'b0;
                end
            end
        end
    end

    assign rx_word       = word_ff;
    assign rx_word_valid = word_vld_ff;

    // ========================================================================
    // events, set wins over clear
    assign events[RXPK_EV_ALIGN_LOSS] = sym_take && !align_ff;
    assign events[RXPK_EV_DISP]       = sym_take && sym_disp_err;
    assign events[RXPK_EV_CVIOL]      = sym_take && sym_cviol &&
                                        (mode != RXPK_MODE_W20);
    assign events[RXPK_EV_RM]         = sym_take && (mode != RXPK_MODE_PIPE)
                                        && (sym_rm_del || sym_rm_ins);

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
    assign bus_wr  = bus_req && wb_we_i && addr_ok && wb_sel_i[0];
    assign addr_ok = adr_valid(wb_adr_i);

    always_comb begin
        nxt_irq = irq_ff;
        if (bus_wr && wb_adr_i == RXPK_IRQ_OFS) begin
            nxt_irq = irq_ff & ~wb_dat_i[RXPK_EV_N-1:0];
        end
        nxt_irq = nxt_irq | events;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_ff <= '0;
        end else if (clk_en) begin
            irq_ff <= nxt_irq;
        end
    end

    assign irq = |(irq_ff & mask_ff);

    // ========================================================================
    // writable registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= RXPK_CTRL_RST;
            mask_ff <= '0;
        end else if (clk_en && bus_wr) begin
            if (wb_adr_i == RXPK_CTRL_OFS) begin
                ctrl_ff <= wb_dat_i[3:0];
            end
            if (wb_adr_i == RXPK_MASK_OFS) begin
                mask_ff <= wb_dat_i[RXPK_EV_N-1:0];
            end
        end
    end

    // ========================================================================
    // bus answer: one wait state, ack or err for one cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_ff  <= 1'b0;
            err_ff  <= 1'b0;
            rdat_ff <= '0;
        end else if (clk_en) begin
            ack_ff <= bus_req && addr_ok;
            err_ff <= bus_req && !addr_ok;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    RXPK_CTRL_OFS: rdat_ff <= {28'h0000000, ctrl_ff};
                    RXPK_STAT_OFS: rdat_ff <= {29'h00000000, half_ff,
                                               align_ff, div_ph_ff};
                    RXPK_IRQ_OFS:  rdat_ff <= {28'h0000000, irq_ff};
                    RXPK_MASK_OFS: rdat_ff <= {28'h0000000, mask_ff};
                    RXPK_WORD_OFS: rdat_ff <= word_ff;
                    default:       rdat_ff <= 32'h00000000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;
    assign wb_dat_o = rdat_ff;
endmodule : rxpk_packer
`default_nettype wire

// ==== logic/rxpk_slot.sv ====
`timescale 1ns/100ps
`default_nettype none
module rxpk_slot
    import rxpk_pkg::*;
(
    // symbol in
    input  wire logic [9:0] sym,
    input  wire logic       ctrl,
    input  wire logic       cviol,
    input  wire logic       align,
    input  wire logic       disp_err,
    input  wire logic       patt,
    input  wire logic       rm_del,
    input  wire logic       rm_ins,
    input  wire logic [1:0] pipe_st,
    input  wire logic       rdisp,
    // selection
    input  wire logic [1:0] mode,
    // packed slot
    output logic      [15:0] slot
);
    always_comb begin
        slot = '0;
        if (mode == RXPK_MODE_W20) begin
            slot[RXPK_DATA_LSB +: 10] = sym;
        end else begin
            slot[RXPK_DATA_LSB +: 8] = sym[7:0];
            slot[RXPK_CTRL_BIT]  = ctrl;
            slot[RXPK_CVIOL_BIT] = cviol;
        end
        slot[RXPK_ALIGN_BIT] = align;
        slot[RXPK_DISP_BIT]  = disp_err;
        slot[RXPK_PATT_BIT]  = patt;
        if (mode == RXPK_MODE_PIPE) begin
            slot[RXPK_DEL_BIT +: 2] = pipe_st;
        end else begin
            slot[RXPK_DEL_BIT] = rm_del;
            slot[RXPK_INS_BIT] = rm_ins;
        end
        slot[RXPK_RDISP_BIT] = rdisp;
    end
endmodule : rxpk_slot
`default_nettype wire
